// file: core/rmsc_rate_mode_ctrl.sv
// rate and mode selection, status byte and response timing of the module
//
// Function
// - all rate inputs zero selects 16G nrz
// - any rate input one selects 32G nrz
// - mode bit one forces 64G pam4
// - tx and rx share one rate
// - mode bit resets to zero
// - tx configured bit after high rate setup
// - rx configured bit after high rate setup
// - tx lol bit, also equalizer done in pam4
// - rx lol bit, also equalizer done in pam4
// - pin rate change applied within 4 ms
// - soft rate change applied within 500 ms
// - mode change completes within 2 s
// - disable pin stops laser, release resumes
// - fault output within 1 ms of fault
// - init clears fault within 10 us
// - loss of signal output within 100 us
// - soft disable and status within 100 ms
// - tx lol bit within 100 ms
// - rx lol bit within 40 ms
// - serial bus ready within 300 ms
// - high or open disable pin stops laser
`timescale 1ns/1ps
`include "rmsc_consts.svh"
`default_nettype none
module rmsc_rate_mode_ctrl #(
    parameter int SERIAL_READY_CYC = `RMSC_T_SERIAL_CYC, // bus ready delay
    parameter int MODE_CFG_CYC     = `RMSC_T_MODE_CYC    // pam4 setup time
) (
    input  wire logic            clock,         // 25 MHz block clock
    input  wire logic            rst,           // async reset, active high
    input  wire logic            hw_rate_pin_a, // hardware rate pin a
    input  wire logic            hw_rate_pin_b, // hardware rate pin b
    input  wire logic            txDisablePin,  // high or open: laser off
    input  wire logic            laserFault,    // laser fault detector
    input  wire logic            opticalLost,   // optical input lost
    input  wire logic            txCdrLocked,   // tx cdr lock indication
    input  wire logic            rxCdrLocked,   // rx cdr lock indication
    input  wire logic            txEqAdapted,   // tx equalizer adapted
    input  wire logic            rxEqAdapted,   // rx equalizer adapted
    input  wire logic            regWrEn,       // register write strobe
    input  wire logic            regRdEn,       // register read strobe
    input  wire logic [7:0]      regAddr,       // register byte address
    input  wire logic [7:0]      regWrData,     // register write data
    output logic [7:0]           regRdData,     // read data, one cycle late
    output logic                 busReady,      // serial bus accepts access
    output rmsc_pkg::rmsc_rate_t txRate,        // rate applied to tx
    output rmsc_pkg::rmsc_rate_t rxRate,        // rate applied to rx
    output logic                 laserOn,       // modulated output enabled
    output logic                 txFault,       // transmit fault output
    output logic                 rx_signal_lost // loss of signal output
);
    // software control bits
    logic softRateA;                          // byte 110 bit 3
    logic softRateB;                          // byte 118 bit 3
    logic softTxOff;                          // byte 110 bit 6
    logic modeBit;                            // byte 119 bit 2
    logic next_softRateA, next_softRateB, next_softTxOff, next_modeBit;
    logic [7:0] next_regRdData;

    // status flops
    logic txLol;                              // byte 119 bit 1
    logic rxLol;                              // byte 119 bit 0
    logic txCfg;                              // byte 119 bit 4
    logic rxCfg;                              // byte 119 bit 3
    logic next_txLol, next_rxLol, next_txCfg, next_rxCfg;

    // mode sequence
    rmsc_pkg::rmsc_state_t state, next_state;
    logic prevModeBit;                        // mode bit one cycle ago
    logic modeTimerExp;                       // reconfiguration done pulse

    // power-on, bus ready and fault clearing
    logic bootPend;                           // first cycle after reset
    logic next_busReady;
    logic busTimerExp;                        // bus ready delay elapsed
    logic prevTxDis;                          // disable pin one cycle ago
    logic holdTimerExp;                       // disable held long enough
    logic next_txFault, next_laserOn, next_los;
    rmsc_pkg::rmsc_rate_t next_rate;

    logic wrOk;                               // write accepted this cycle
    assign wrOk = regWrEn && busReady;

    // bus ready delay starts once the reset is released
    rmsc_timer #(.CYCLES(SERIAL_READY_CYC)) u_busTimer (
        .clock   (clock),
        .rst     (rst),
        .start   (bootPend),
        .abort   (1'b0),
        .busy    (),
        .expired (busTimerExp)
    );

    // restart on every mode toggle so only the latest request completes
    rmsc_timer #(.CYCLES(MODE_CFG_CYC)) u_modeTimer (
        .clock   (clock),
        .rst     (rst),
        .start   (modeBit ^ prevModeBit),
        .abort   (1'b0),
        .busy    (),
        .expired (modeTimerExp)
    );

    // a fault only clears if the pin stays high for the whole hold time
    rmsc_timer #(.CYCLES(`RMSC_T_RESET_CYC)) u_holdTimer (
        .clock   (clock),
        .rst     (rst),
        .start   (txDisablePin && !prevTxDis),
        .abort   (!txDisablePin),
        .busy    (),
        .expired (holdTimerExp)
    );

    // register writes and reads; nothing is taken before the bus is ready
    always_comb begin
        next_softRateA = softRateA;
        next_softRateB = softRateB;
        next_softTxOff = softTxOff;
        next_modeBit   = modeBit;
        next_regRdData = regRdData;
        if (wrOk) begin
            case (regAddr)
                `RMSC_OFS_CTRL_A: begin
                    next_softRateA = regWrData[`RMSC_BIT_RATE];
                    next_softTxOff = regWrData[`RMSC_BIT_TXOFF];
                end
                `RMSC_OFS_RATE_B: begin
                    next_softRateB = regWrData[`RMSC_BIT_RATE];
                end
                `RMSC_OFS_HR_MODE: begin
                    next_modeBit = regWrData[`RMSC_BIT_HR_MODE];
                end
                default: begin
                    // unmapped byte: write ignored
                end
            endcase
        end
        if (regRdEn) begin
            next_regRdData = 8'h00;                // unmapped reads zero
            if (busReady) begin
                case (regAddr)
                    `RMSC_OFS_CTRL_A: begin
                        next_regRdData[`RMSC_BIT_TXOFF] = softTxOff;
                        next_regRdData[`RMSC_BIT_RATE]  = softRateA;
                        next_regRdData[`RMSC_BIT_FAULT] = txFault;
                        next_regRdData[`RMSC_BIT_LOS]   = rx_signal_lost;
                    end
                    `RMSC_OFS_RATE_B: begin
                        next_regRdData[`RMSC_BIT_RATE] = softRateB;
                    end
                    `RMSC_OFS_HR_MODE: begin   // upper three bits read zero
                        next_regRdData[`RMSC_BIT_TX_CFG]  = txCfg;
                        next_regRdData[`RMSC_BIT_RX_CFG]  = rxCfg;
                        next_regRdData[`RMSC_BIT_HR_MODE] = modeBit;
                        next_regRdData[`RMSC_BIT_TX_LOL]  = txLol;
                        next_regRdData[`RMSC_BIT_RX_LOL]  = rxLol;
                    end
                    default: begin
                        next_regRdData = 8'h00;
                    end
                endcase
            end
        end
    end

    // register file flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            softRateA <= 1'b0;
            softRateB <= 1'b0;
            softTxOff <= 1'b0;
            modeBit   <= `RMSC_HR_MODE_RESET;
            regRdData <= 8'h00;
        end else begin
            softRateA <= next_softRateA;
            softRateB <= next_softRateB;
            softTxOff <= next_softTxOff;
            modeBit   <= next_modeBit;
            regRdData <= next_regRdData;
        end
    end

    // rate follows inputs next cycle, far inside the pin and soft limits;
    // one value feeds both directions so they can never disagree
    always_comb begin
        if (modeBit) begin
            next_rate = rmsc_pkg::RMSC_RATE_64G;
        end else if (softRateA || softRateB
                     || hw_rate_pin_a || hw_rate_pin_b) begin
            next_rate = rmsc_pkg::RMSC_RATE_32G;
        end else begin
            next_rate = rmsc_pkg::RMSC_RATE_16G;
        end
    end

    // rate flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txRate <= rmsc_pkg::RMSC_RATE_16G;
            rxRate <= rmsc_pkg::RMSC_RATE_16G;
        end else begin
            txRate <= next_rate;
            rxRate <= next_rate;
        end
    end

    // high rate configuration sequence and status bits
    always_comb begin
        next_state = state;
        case (state)
            rmsc_pkg::RMSC_NRZ_RUN: begin
                if (modeBit) next_state = rmsc_pkg::RMSC_TO_PAM;
            end
            rmsc_pkg::RMSC_TO_PAM: begin
                if (!modeBit) next_state = rmsc_pkg::RMSC_TO_NRZ;
                else if (modeTimerExp) next_state = rmsc_pkg::RMSC_PAM_RUN;
            end
            rmsc_pkg::RMSC_PAM_RUN: begin
                if (!modeBit) next_state = rmsc_pkg::RMSC_TO_NRZ;
            end
            rmsc_pkg::RMSC_TO_NRZ: begin
                if (modeBit) next_state = rmsc_pkg::RMSC_TO_PAM;
                else if (modeTimerExp) next_state = rmsc_pkg::RMSC_NRZ_RUN;
            end
            default: begin
                next_state = rmsc_pkg::RMSC_NRZ_RUN;    // illegal code
            end
        endcase
        // configured bits only in steady pam4 and drop one cycle after the bit clears
        next_txCfg = (next_state == rmsc_pkg::RMSC_PAM_RUN);
        next_rxCfg = (next_state == rmsc_pkg::RMSC_PAM_RUN);
        // in configured pam4 a locked cdr also needs its equalizer adapted
        next_txLol = !txCdrLocked
                   || (modeBit && txCfg && !txEqAdapted);
        next_rxLol = !rxCdrLocked
                   || (modeBit && rxCfg && !rxEqAdapted);
    end

    // sequence flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state       <= rmsc_pkg::RMSC_NRZ_RUN;
            prevModeBit <= `RMSC_HR_MODE_RESET;
            txCfg       <= 1'b0;
            rxCfg       <= 1'b0;
            txLol       <= 1'b1;
            rxLol       <= 1'b1;
        end else begin
            state       <= next_state;
            prevModeBit <= modeBit;
            txCfg       <= next_txCfg;
            rxCfg       <= next_rxCfg;
            txLol       <= next_txLol;
            rxLol       <= next_rxLol;
        end
    end

    // transmitter, fault and loss of signal; a new fault beats the clear
    always_comb begin
        next_busReady = busReady || busTimerExp;
        next_txFault  = laserFault
                      || (txFault && !holdTimerExp);
        next_laserOn  = !txDisablePin && !softTxOff
                      && !next_txFault;
        next_los      = opticalLost;
    end

    // output flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bootPend       <= 1'b1;
            busReady       <= 1'b0;
            prevTxDis      <= 1'b1;
            txFault        <= 1'b0;
            laserOn        <= 1'b0;
            rx_signal_lost <= 1'b0;
        end else begin
            bootPend       <= 1'b0;
            busReady       <= next_busReady;
            prevTxDis      <= txDisablePin;
            txFault        <= next_txFault;
            laserOn        <= next_laserOn;
            rx_signal_lost <= next_los;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_rate16;
        !modeBit && !softRateA && !softRateB && !hw_rate_pin_a
            && !hw_rate_pin_b |=> txRate == rmsc_pkg::RMSC_RATE_16G;
    endproperty
    a_rate16: assert property (p_rate16) else $error("16G not chosen");
    property p_rate32;
        !modeBit && (softRateA || hw_rate_pin_b)
            |=> rxRate == rmsc_pkg::RMSC_RATE_32G;
    endproperty
    a_rate32: assert property (p_rate32) else $error("32G not chosen");
    property p_rate64;
        modeBit |=> txRate == rmsc_pkg::RMSC_RATE_64G;
    endproperty
    a_rate64: assert property (p_rate64) else $error("64G not chosen");
    property p_same;
        txRate == rxRate;
    endproperty
    a_same: assert property (p_same) else $error("tx and rx rates differ");
    property p_modeReset;
        $past(rst) |-> !modeBit && !txCfg;
    endproperty
    a_modeReset: assert property (p_modeReset) else $error("mode bit set");
    // a configured bit can only stand if the mode bit was set an edge ago
    property p_cfgDone;
        txCfg || rxCfg |-> $past(modeBit);
    endproperty
    a_cfgDone: assert property (p_cfgDone) else $error("cfg early");
    property p_cfgSet;
        state == rmsc_pkg::RMSC_TO_PAM && modeBit && modeTimerExp
            |=> txCfg && rxCfg;
    endproperty
    a_cfgSet: assert property (p_cfgSet) else $error("cfg not set");
    property p_cfgClr;
        modeBit ##1 !modeBit |=> !txCfg && !rxCfg;
    endproperty
    a_cfgClr: assert property (p_cfgClr) else $error("cfg not cleared");
    property p_txLol;
        !txCdrLocked |=> txLol;
    endproperty
    a_txLol: assert property (p_txLol) else $error("tx lol missed");
    property p_rxLol;
        rxCdrLocked && !(modeBit && rxCfg) |=> !rxLol;
    endproperty
    a_rxLol: assert property (p_rxLol) else $error("rx lol stuck");
    property p_txOff;
        txDisablePin |=> !laserOn;
    endproperty
    a_txOff: assert property (p_txOff) else $error("laser not off");
    property p_fault;
        laserFault |=> txFault ##1 (txFault || $past(holdTimerExp));
    endproperty
    a_fault: assert property (p_fault) else $error("fault not shown");
    property p_los;
        ##1 rx_signal_lost == $past(opticalLost);
    endproperty
    a_los: assert property (p_los) else $error("los not followed");

    c_pam: cover property (state == rmsc_pkg::RMSC_PAM_RUN && txCfg);
    c_r32: cover property (txRate == rmsc_pkg::RMSC_RATE_32G);
    c_fclr: cover property ($fell(txFault));
    c_back: cover property (modeBit ##1 !modeBit);
endmodule : rmsc_rate_mode_ctrl
`default_nettype wire

// file: pkg/rmsc_consts.svh
// constants for the rate and mode select control block
`ifndef RMSC_CONSTS_SVH
`define RMSC_CONSTS_SVH

`define RMSC_OFS_CTRL_A      8'h6E   // byte with soft rate A, soft tx off
`define RMSC_OFS_RATE_B      8'h76   // byte with soft rate B
`define RMSC_OFS_HR_MODE     8'h77   // high rate mode control/status byte

`define RMSC_BIT_RX_LOL      0       // rx cdr not locked
`define RMSC_BIT_TX_LOL      1       // tx cdr not locked
`define RMSC_BIT_HR_MODE     2       // high rate mode control
`define RMSC_BIT_RX_CFG      3       // rx configured for high rate
`define RMSC_BIT_TX_CFG      4       // tx configured for high rate
`define RMSC_BIT_LOS         1       // soft loss of signal
`define RMSC_BIT_FAULT       2       // soft transmit fault
`define RMSC_BIT_RATE        3       // soft rate bit (both bytes)
`define RMSC_BIT_TXOFF       6       // soft transmitter disable

`define RMSC_HR_MODE_RESET   1'h0    // mode bit value after power up

`define RMSC_CLK_HZ          25000000
`define RMSC_T_RESET_US      10      // disable hold to clear a fault
`define RMSC_T_RESET_CYC     ((`RMSC_T_RESET_US * `RMSC_CLK_HZ + 999999) / 1000000)
`define RMSC_T_SERIAL_MS     300     // serial bus ready after power on
`define RMSC_T_SERIAL_CYC    ((`RMSC_CLK_HZ / 1000) * `RMSC_T_SERIAL_MS)
`define RMSC_T_MODE_S        2       // high rate mode reconfiguration
`define RMSC_T_MODE_CYC      (`RMSC_CLK_HZ * `RMSC_T_MODE_S)

`endif

// file: pkg/rmsc_pkg.sv
// types shared by the rate and mode select control block
package rmsc_pkg;

    // line rate applied to both directions
    typedef enum logic [2:0] {
        RMSC_RATE_16G = 3'h1,   // nrz, low rate
        RMSC_RATE_32G = 3'h2,   // nrz, high rate
        RMSC_RATE_64G = 3'h4    // pam4
    } rmsc_rate_t;

    // high rate mode reconfiguration sequence
    typedef enum logic [3:0] {
        RMSC_NRZ_RUN = 4'h1,    // nrz rates in force
        RMSC_TO_PAM  = 4'h2,    // configuring into pam4
        RMSC_PAM_RUN = 4'h4,    // pam4 configured
        RMSC_TO_NRZ  = 4'h8     // configuring out of pam4
    } rmsc_state_t;

endpackage : rmsc_pkg

// file: core/rmsc_timer.sv
// one-shot cycle timer with restart and abort
`timescale 1ns/1ps
`default_nettype none
module rmsc_timer #(
    parameter int CYCLES = 250                // cycles from start to expiry
) (
    input  wire logic clock,                  // block clock
    input  wire logic rst,                    // async reset, active high
    input  wire logic start,                  // restart the count
    input  wire logic abort,                  // stop without expiry
    output logic      busy,                   // counting
    output logic      expired                 // one-cycle expiry pulse
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt;                         // elapsed cycles
    logic [W-1:0] next_cnt;
    logic         next_busy;
    logic         next_expired;

    // restart wins over abort so a fresh start is never lost
    always_comb begin
        next_cnt     = cnt;
        next_busy    = busy;
        next_expired = 1'b0;
        if (start) begin
            next_cnt  = '0;
            next_busy = 1'b1;
        end else if (abort) begin
            next_busy = 1'b0;
        end else if (busy) begin
            if (cnt == W'(CYCLES - 1)) begin
                next_busy    = 1'b0;
                next_expired = 1'b1;
            end else begin
                next_cnt = cnt + W'(1);
            end
        end
    end

    // register the count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt     <= '0;
            busy    <= 1'b0;
            expired <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            busy    <= next_busy;
            expired <= next_expired;
        end
    end
endmodule : rmsc_timer
`default_nettype wire

// file: verification/rmsc_host.sv
// host board model: register port accesses and the disable pin
`timescale 1ns/1ps
`default_nettype none
module rmsc_host #(
    parameter int IDLE_CYC = 500,       // bus idle after each access, 20 us
    parameter int HOLD_CYC = 256        // disable hold that clears a fault
) (
    input  wire logic       clock,        // block clock
    input  wire logic [7:0] regRdData,    // read byte from the device
    output logic            regWrEn,      // write strobe
    output logic            regRdEn,      // read strobe
    output logic [7:0]      regAddr,      // byte address
    output logic [7:0]      regWrData,    // write byte
    output logic            txDisablePin  // disable pin, open reads high
);
    // pin starts high: an unplugged host leaves it pulled up
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        txDisablePin = 1'b1;
    end

    // gap after every stop, so no access follows too closely
    task automatic idle();
        repeat (IDLE_CYC) @(posedge clock);
        #1;
    endtask : idle

    // one byte write; released lines show inverted values, not stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clock);
        #1;
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
        idle();
    endtask : wr

    // one byte read; data is taken once the answer edge has passed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clock);
        #1;
        regRdEn = 1'b0;
        regAddr = ~a;
        @(posedge clock);
        #1;
        d = regRdData;
        idle();
    endtask : rd

    // drive the disable pin to a level
    task automatic pin(input logic v);
        @(posedge clock);
        #1;
        txDisablePin = v;
    endtask : pin

    // hold disable high for n cycles, then release it low
    task automatic hold(input int n);
        pin(1'b1);
        repeat (n) @(posedge clock);
        #1;
        txDisablePin = 1'b0;
    endtask : hold
endmodule : rmsc_host
`default_nettype wire

// file: verification/rmsc_rate_mode_ctrl_tb_top.sv
// self-checking bench of the rate and mode select control block
`timescale 1ns/1ps
`default_nettype none
module rmsc_rate_mode_ctrl_tb_top;
    localparam int SER = 20;            // shortened bus ready delay
    logic                 clock, rst;   // clock and reset
    logic                 pinA, pinB;   // hardware rate pins
    logic                 laserFault, opticalLost; // event inputs
    logic                 txLock, rxLock, txEq, rxEq; // cdr and eq state
    logic                 wrEn, rdEn, txDis;  // host strobes and pin
    logic [7:0]           addr, wrData, rdData, d; // register port
    logic                 busReady, laserOn, txFault, sigLost; // outputs
    rmsc_pkg::rmsc_rate_t txRate, rxRate; // applied rates
    int                   n_fail, n_checks, n;

    rmsc_rate_mode_ctrl #(.SERIAL_READY_CYC(SER), .MODE_CFG_CYC(10))
        i_rmsc_rate_mode_ctrl (.clock(clock), .rst(rst),
        .hw_rate_pin_a(pinA), .hw_rate_pin_b(pinB), .txDisablePin(txDis),
        .laserFault(laserFault), .opticalLost(opticalLost),
        .txCdrLocked(txLock), .rxCdrLocked(rxLock), .txEqAdapted(txEq),
        .rxEqAdapted(rxEq), .regWrEn(wrEn), .regRdEn(rdEn),
        .regAddr(addr), .regWrData(wrData), .regRdData(rdData),
        .busReady(busReady), .txRate(txRate), .rxRate(rxRate),
        .laserOn(laserOn), .txFault(txFault), .rx_signal_lost(sigLost));

    rmsc_host i_rmsc_host (.clock(clock), .regRdData(rdData),
        .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr),
        .regWrData(wrData), .txDisablePin(txDis));

    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // compare one value, four-state exact
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // both directions always carry the same rate
    task automatic rates(input logic [2:0] e);
        chk("txRate", {5'h00, e}, {5'h00, txRate});
        chk("rxRate", {5'h00, e}, {5'h00, rxRate});
    endtask : rates

    // let n edges pass, inputs then change just after the edge
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : step

    // register read with expected byte
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        i_rmsc_host.rd(a, d);
        chk("regRdData", e, d);
    endtask : rdc

    // set one of the four nrz rate sources
    task automatic src(input int k, input logic v);
        case (k)
            0: pinA = v;
            1: pinB = v;
            2: i_rmsc_host.wr(8'h6E, {4'h0, v, 3'h0});
            default: i_rmsc_host.wr(8'h76, {4'h0, v, 3'h0});
        endcase
        step(3);
    endtask : src

    // single end of the run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // hang guard
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        close_out();
    end

    // main sequence
    initial begin
        n_fail = 0;
        n_checks = 0;
        {pinA, pinB, laserFault, opticalLost} = 4'h0;
        {txLock, rxLock, txEq, rxEq} = 4'hF;
        rst = 1'b1;
        step(16);
        rst = 1'b0;
        chk("busReady", 8'h00, {7'h00, busReady});
        n = 0;
        while (busReady !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        if (n != SER + 2) begin
            n_fail++;
            $display("CHECK FAILED busReady delay expected %0d seen %0d",
                     SER + 2, n);
        end
        rates(3'h1);
        chk("laserOn", 8'h00, {7'h00, laserOn});
        rdc(8'h77, 8'h00);
        rdc(8'h10, 8'h00);
        // each source alone moves both directions to 32G and back
        for (int k = 0; k < 4; k++) begin
            src(k, 1'b1);
            rates(3'h2);
            src(k, 1'b0);
            rates(3'h1);
        end
        // high rate mode overrides the pins
        pinA = 1'b1;
        {txEq, rxEq} = 2'b01;
        i_rmsc_host.wr(8'h77, 8'h04);
        rates(3'h4);
        rdc(8'h77, 8'h1E);
        {txEq, rxEq} = 2'b10;
        rdc(8'h77, 8'h1D);
        {txEq, rxEq} = 2'b11;
        i_rmsc_host.wr(8'h77, 8'hFF);
        rdc(8'h77, 8'h1C);
        i_rmsc_host.wr(8'h77, 8'h00);
        rdc(8'h77, 8'h00);
        rates(3'h2);
        pinA = 1'b0;
        // loss of lock in nrz
        rxLock = 1'b0;
        rdc(8'h77, 8'h01);
        txLock = 1'b0;
        rdc(8'h77, 8'h03);
        {txLock, rxLock} = 2'b11;
        rdc(8'h77, 8'h00);
        // disable pin and soft disable
        i_rmsc_host.pin(1'b0);
        step(3);
        chk("laserOn", 8'h01, {7'h00, laserOn});
        i_rmsc_host.wr(8'h6E, 8'h40);
        chk("laserOn", 8'h00, {7'h00, laserOn});
        i_rmsc_host.wr(8'h6E, 8'h00);
        // latched fault; a short disable pulse must not clear it
        laserFault = 1'b1;
        step(3);
        chk("txFault", 8'h01, {7'h00, txFault});
        chk("laserOn", 8'h00, {7'h00, laserOn});
        rdc(8'h6E, 8'h04);
        laserFault = 1'b0;
        i_rmsc_host.hold(100);
        step(3);
        chk("txFault", 8'h01, {7'h00, txFault});
        i_rmsc_host.hold(256);
        step(3);
        chk("txFault", 8'h00, {7'h00, txFault});
        chk("laserOn", 8'h01, {7'h00, laserOn});
        // loss of optical input
        opticalLost = 1'b1;
        step(3);
        chk("sigLost", 8'h01, {7'h00, sigLost});
        rdc(8'h6E, 8'h02);
        opticalLost = 1'b0;
        step(3);
        chk("sigLost", 8'h00, {7'h00, sigLost});
        close_out();
    end
endmodule : rmsc_rate_mode_ctrl_tb_top
`default_nettype wire
